//--- verif/asp_control_checker.sv
// Checker: bus timing, pin ownership and request gating of the serial port control block
`timescale 1ns/100ps
module asp_control_checker
   import asp_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [3:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic stb_i,
   input wire logic cyc_i,
   input wire logic ack_o,
   input wire logic transmitPinDirection,
   input wire logic transmitPortData,
   input wire logic receivePinDirection,
   input wire logic transmitPinOut,
   input wire logic transmitPinOe,
   input wire logic receivePinOe,
   input wire logic txIrq,
   input wire logic rxIrq
);
   // ****************************************
   // Shadow of the control registers
   // ****************************************
   logic [7:0] ctlOne_r;
   logic [7:0] ctlTwo_r;
   logic wrTake;
   // A write lands at the edge that takes it
   assign wrTake = cyc_i & stb_i & ~ack_o & we_i & sel_i[0];
   // Transmitter and receiver enable bits keep their value while the port is off
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctlOne_r <= CTRL_RESET;
         ctlTwo_r <= CTRL_RESET;
      end else if (wrTake && adr_i == ADR_CTRL_ONE) begin
         ctlOne_r <= dat_i[7:0];
      end else if (wrTake && adr_i == ADR_CTRL_TWO) begin
         ctlTwo_r <= ctlOne_r[C1_ENABLE] ? dat_i[7:0] : {dat_i[7:4], ctlTwo_r[3:2], dat_i[1:0]};
      end
   end
   // ****************************************
   // Properties
   // ****************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   a_tx_pin_owned: assert property (ctlOne_r[C1_ENABLE] |-> transmitPinOe)
      else $error("transmit pin not driven while port enabled");
   a_rx_pin_input: assert property (ctlOne_r[C1_ENABLE] |-> !receivePinOe)
      else $error("receive pin driven while port enabled");
   a_port_fallback: assert property (!ctlOne_r[C1_ENABLE] |-> transmitPinOut == transmitPortData
      && transmitPinOe == transmitPinDirection && receivePinOe == receivePinDirection)
      else $error("pins do not follow port settings while port off");
   a_ack_one_wait: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus answer not given one cycle after request");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("bus answer longer than one cycle");
   a_tx_irq_gate: assert property (txIrq |-> $past(ctlOne_r[C1_ENABLE]
      && (ctlTwo_r[C2_TXEIE] || ctlTwo_r[C2_TX_COMPLETE_IRQ_ENABLE])))
      else $error("transmit request without enable");
   a_rx_irq_gate: assert property (rxIrq |-> $past(!ctlTwo_r[C2_STBY]
      && (ctlTwo_r[C2_RXFIE] || ctlTwo_r[C2_IDLEIE])))
      else $error("receive request without enable");
   a_ctl_one_read: assert property (ack_o && !we_i && adr_i == ADR_CTRL_ONE
      |-> dat_o == {24'h000000, ctlOne_r})
      else $error("control one readback wrong");
   a_ctl_two_read: assert property (ack_o && !we_i && adr_i == ADR_CTRL_TWO
      |-> dat_o == {24'h000000, ctlTwo_r})
      else $error("control two readback wrong");
   c_tx_irq: cover property ($rose(txIrq));
   c_rx_irq: cover property ($rose(rxIrq));
   c_data_read: cover property (ack_o && !we_i && adr_i == ADR_DATA);
endmodule : asp_control_checker

bind asp_control asp_control_checker u_asp_control_checker (.core_clk(core_clk), .srst(srst),
   .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i),
   .cyc_i(cyc_i), .ack_o(ack_o), .transmitPinDirection(transmitPinDirection),
   .transmitPortData(transmitPortData), .receivePinDirection(receivePinDirection),
   .transmitPinOut(transmitPinOut), .transmitPinOe(transmitPinOe),
   .receivePinOe(receivePinOe), .txIrq(txIrq), .rxIrq(rxIrq));

//--- verif/asp_control_tb_top.sv
// Testbench: register sequences and serial frame checks for the serial port control block
`timescale 1ns/100ps
module asp_control_tb_top;
   import asp_pkg::*;
   localparam int TICK_LIMIT = 95000;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] adr = 4'h0;
   logic [31:0] datW = 32'h0;
   logic [31:0] datR;
   logic we = 1'b0;
   logic [3:0] sel = 4'h0;
   logic stb = 1'b0;
   logic cyc = 1'b0;
   logic ack, txOut, txOe, rxIn, rxOut, rxOe, txIrq, rxIrq;
   logic txDir = 1'b0;
   logic txPort = 1'b1;
   logic rxDir = 1'b1;
   logic rxPort = 1'b0;
   logic rxLow = 1'b0;
   logic [10:0] frameData;
   logic [7:0] frameCount;
   logic [31:0] q;
   logic [6:0] txByte;
   int n_errors = 0;
   int tests_run = 0;
   int ticks = 0;
   int dt;
   asp_control u_asp_control (.core_clk(core_clk), .srst(srst), .adr_i(adr), .dat_i(datW),
      .dat_o(datR), .we_i(we), .sel_i(sel), .stb_i(stb), .cyc_i(cyc), .ack_o(ack),
      .transmitPinDirection(txDir), .transmitPortData(txPort), .receivePinDirection(rxDir),
      .receivePortData(rxPort), .transmitPinOut(txOut), .transmitPinOe(txOe),
      .receivePinIn(rxIn), .receivePinOut(rxOut), .receivePinOe(rxOe), .txIrq(txIrq),
      .rxIrq(rxIrq));
   asp_serial_partner u_asp_serial_partner (.core_clk(core_clk), .srst(srst), .lineIn(txOut),
      .lineOe(txOe), .frameBits(FRAME_SHORT), .rxLow(rxLow), .lineOut(rxIn),
      .frameData(frameData), .frameCount(frameCount));
   // Free-running 25 MHz clock
   always #20 core_clk = ~core_clk;
   // Watchdog sized for three full frames plus register traffic
   always @(posedge core_clk) begin
      ticks <= ticks + 1;
      if (ticks == TICK_LIMIT) begin
         n_errors++;
         $display("unexpected timeout: expected finish seen hang");
         test_done();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // One classic cycle; held until ack is sampled high
   task automatic wbXfer(input logic [3:0] a, input logic w, input logic [31:0] d,
                         output logic [31:0] r);
      @(posedge core_clk);
      adr <= a; we <= w; datW <= d; sel <= 4'hF; cyc <= 1'b1; stb <= 1'b1;
      do @(posedge core_clk); while (ack !== 1'b1);
      r = datR;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask : wbXfer
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] r;
      wbXfer(a, 1'b1, d, r);
   endtask : wr
   task automatic rdChk(input string what, input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] r;
      wbXfer(a, 1'b0, 32'h0, r);
      check(what, r, exp);
   endtask : rdChk
   // Poll status until the transmitter reports completion
   task automatic waitTc(output int elapsed);
      int t0;
      logic [31:0] r;
      t0 = ticks;
      r = 32'h0;
      repeat (4) @(posedge core_clk);
      while (r[ST_TC] !== 1'b1) wbXfer(ADR_STATUS, 1'b0, 32'h0, r);
      elapsed = ticks - t0;
   endtask : waitTc
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      rdChk("ctl one reset", ADR_CTRL_ONE, 32'h0);
      rdChk("ctl two reset", ADR_CTRL_TWO, 32'h0);
      rdChk("status reset", ADR_STATUS, (32'h1 << ST_TXE) | (32'h1 << ST_TC));
      rdChk("unmapped", 4'h2, 32'h0);
      check("tx oe off", {31'h0, txOe}, 32'h0);
      check("rx oe off", {31'h0, rxOe}, 32'h1);
      check("rx port data", {31'h0, rxOut}, 32'h0);
      $display("test reset done");
      wr(ADR_CTRL_TWO, 32'h0000000C);
      rdChk("enables refused", ADR_CTRL_TWO, 32'h0);
      wr(ADR_CTRL_ONE, 32'h00000040);
      check("tx oe on", {31'h0, txOe}, 32'h1);
      check("rx oe on", {31'h0, rxOe}, 32'h0);
      check("idle level", {31'h0, txOut}, 32'h1);
      wr(ADR_CTRL_ONE, 32'h00000060);
      check("inverted idle", {31'h0, txOut}, 32'h0);
      wr(ADR_CTRL_ONE, 32'h00000040);
      for (int i = 0; i < 3; i++) begin
         wr(ADR_CTRL_TWO, {24'h0, (i == 0) ? 8'h80 : (i == 1) ? 8'h40 : 8'h00});
         repeat (2) @(posedge core_clk);
         check("tx irq", {31'h0, txIrq}, (i < 2) ? 32'h1 : 32'h0);
      end
      wr(ADR_CTRL_TWO, 32'h00000080);
      wr(ADR_CTRL_ONE, 32'h00000000);
      repeat (2) @(posedge core_clk);
      check("tx irq port off", {31'h0, txIrq}, 32'h0);
      wr(ADR_CTRL_ONE, 32'h00000040);
      wr(ADR_CTRL_TWO, 32'h00000000);
      $display("test enables done");
      wr(ADR_CTRL_TWO, 32'h00000008);
      waitTc(dt);
      check("preamble len", {31'h0, dt >= 10 * BIT_CYCLES_INT && dt < 11 * BIT_CYCLES_INT},
            32'h1);
      check("preamble no start", {24'h0, frameCount}, 32'h0);
      $display("test preamble done");
      txByte = 7'h35;
      rxLow <= 1'b1;
      wr(ADR_CTRL_ONE, 32'h000000C3);
      wr(ADR_CTRL_TWO, 32'h0000002C);
      wr(ADR_DATA, {25'h0, txByte});
      waitTc(dt);
      check("frame count", {24'h0, frameCount}, 32'h1);
      check("frame bits", {21'h0, frameData}, {22'h0, 1'b1, ~^txByte, txByte, 1'b0});
      check("rx irq", {31'h0, rxIrq}, 32'h1);
      wbXfer(ADR_STATUS, 1'b0, 32'h0, q);
      check("rx status", q & 32'h23, 32'h1 << ST_RXF);
      wbXfer(ADR_DATA, 1'b0, 32'h0, q);
      check("loop data", {25'h0, q[6:0]}, {25'h0, txByte});
      repeat (2) @(posedge core_clk);
      check("rx irq cleared", {31'h0, rxIrq}, 32'h0);
      rxLow <= 1'b0;
      $display("test loop done");
      wr(ADR_CTRL_ONE, 32'h00000040);
      wr(ADR_CTRL_TWO, 32'h00000009);
      repeat (8) @(posedge core_clk);
      wr(ADR_CTRL_TWO, 32'h00000008);
      waitTc(dt);
      repeat (2 * BIT_CYCLES_INT) @(posedge core_clk);
      check("break count", {24'h0, frameCount}, 32'h2);
      check("break bits", {21'h0, frameData}, 32'h0);
      check("mark after break", {31'h0, txOut}, 32'h1);
      wr(ADR_CTRL_TWO, 32'h00000000);
      check("tx off idle", {31'h0, txOut}, 32'h1);
      $display("test break done");
      test_done();
   end
endmodule : asp_control_tb_top

//--- verif/asp_serial_partner.sv
// Partner: far-end serial receiver on the transmit pin and driver of the receive pin
`timescale 1ns/100ps
module asp_serial_partner
   import asp_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic lineIn,
   input wire logic lineOe,
   input wire logic [3:0] frameBits,
   input wire logic rxLow,
   output logic lineOut,
   output logic [10:0] frameData,
   output logic [7:0] frameCount
);
   logic busy;
   logic armed;
   logic [15:0] tick;
   logic [3:0] idx;
   logic lineLvl;
   // Released pin floats to its pull-up; receive pin idles high unless held low
   assign lineLvl = lineOe ? lineIn : 1'b1;
   assign lineOut = ~rxLow;
   // Mid-bit sampler; needs a high line first so a break tail starts no frame
   always_ff @(posedge core_clk) begin
      if (srst) begin
         busy <= 1'b0;
         armed <= 1'b0;
         tick <= 16'h0000;
         idx <= 4'h0;
         frameData <= 11'h000;
         frameCount <= 8'h00;
      end else if (!busy) begin
         if (lineLvl) begin
            armed <= 1'b1;
         end else if (armed) begin
            busy <= 1'b1;
            tick <= HALF_BIT;
            idx <= 4'h0;
         end
      end else if (tick != 16'h0000) begin
         tick <= tick - 16'h0001;
      end else if (idx == 4'h0 && lineLvl) begin
         busy <= 1'b0; // High at mid start bit: a glitch, not a frame
      end else begin
         frameData[idx] <= lineLvl;
         tick <= BIT_CYCLES - 16'h0001;
         idx <= idx + 4'h1;
         if (idx == frameBits - 4'h1) begin
            busy <= 1'b0;
            armed <= 1'b0;
            frameCount <= frameCount + 8'h01;
         end
      end
   end
endmodule : asp_serial_partner

//--- verilog/asp_control.sv
// Module: serial port control, transmitter and receiver behind a Wishbone slave
//
// Behaviour
// - While enabled, the transmit pin is always driven as an output.
// - While enabled, the receive pin is always an input, direction ignored.
// - Loop mode feeds transmitter output to receiver; software enables both.
// - Module enable runs port and baud; clearing sets empty/complete, masks tx irq.
// - Invert bit flips every transmitted level including idle and break.
// - Character length bit picks 8 or 9 data bits; 10 or 11 bit frames.
// - Parity sits in the top data position; type ignored when parity off.
// - Parity type one is odd, zero is even, on send and receive.
// - Parity type changes mid-frame may yield parity errors; change when quiet.
// - Wake bit one means address mark, zero means idle line.
// - Idle count of ones starts after stop bit or after start bit.
// - Transmitter empty raises tx request only when its enable is set.
// - Transmission complete raises tx request only when its enable is set.
// - Receiver full raises rx request only when its enable is set.
// - Idle flag raises rx request only when its enable is set.
// - Setting transmitter enable sends one all-ones preamble frame.
// - Clearing transmitter enable finishes current frame then idles high.
// - Clear then set of transmitter enable mid-frame queues one idle frame.
// - Receiver enable gates reception; clearing keeps receiver flags.
// - Standby bit masks rx requests; hardware clears it on wake condition.
// - Break pulse sends one break then a single one; held sends back to back.
// - Address wake sets receiver full; idle wake sets neither idle nor full.
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module asp_control
   import asp_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [3:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic stb_i,
   input wire logic cyc_i,
   output logic ack_o,
   input wire logic transmitPinDirection,
   input wire logic transmitPortData,
   input wire logic receivePinDirection,
   input wire logic receivePortData,
   output logic transmitPinOut,
   output logic transmitPinOe,
   input wire logic receivePinIn,
   output logic receivePinOut,
   output logic receivePinOe,
   output logic txIrq,
   output logic rxIrq
);
   // ****************************************
   // Helpers
   // ****************************************
   // Frame length in bits from the character length bit
   function automatic logic [3:0] frameLen(input logic m);
      frameLen = m ? FRAME_LONG : FRAME_SHORT;
   endfunction : frameLen
   // Parity of the data bits below the parity slot
   function automatic logic parityOf(input logic [8:0] d, input logic m, input logic odd);
      logic p;
      p = m ? ^d[7:0] : ^d[6:0];
      parityOf = p ^ odd;
   endfunction : parityOf

   logic [7:0] ctrlOne_r;
   logic [7:0] ctrlTwo_r;
   logic ackR;
   logic access;
   logic wrOne, wrTwo, wrData, rdData;
   logic enable, modeLong;
   logic rxSync1_r, rxSync2_r;
   logic txBit;
   logic rxLine;

   assign enable = ctrlOne_r[C1_ENABLE];
   assign modeLong = ctrlOne_r[C1_MODE];
   assign access = cyc_i & stb_i & ~ackR;
   assign wrOne = access & we_i & sel_i[0] & (adr_i == ADR_CTRL_ONE);
   assign wrTwo = access & we_i & sel_i[0] & (adr_i == ADR_CTRL_TWO);
   assign wrData = access & we_i & sel_i[0] & (adr_i == ADR_DATA);
   assign rdData = access & ~we_i & (adr_i == ADR_DATA);

   // ****************************************
   // Pins
   // ****************************************
   // Port direction only counts while the serial port is off
   assign transmitPinOe = enable | transmitPinDirection;
   assign transmitPinOut = enable ? (txBit ^ ctrlOne_r[C1_TRANSMIT_INVERT])
                                  : transmitPortData;
   assign receivePinOe = ~enable & receivePinDirection;
   assign receivePinOut = receivePortData;

   // Receive pin synchroniser, first stage feeds only the second
   always_ff @(posedge core_clk) begin
      rxSync1_r <= receivePinIn;
      rxSync2_r <= rxSync1_r;
   end
   // Loop mode cuts the pin off and listens to the raw transmitter
   assign rxLine = ctrlOne_r[C1_LOOP] ? txBit : rxSync2_r;

   // ****************************************
   // Wishbone slave
   // ****************************************
   logic [8:0] txData_r, rxData_r;
   logic txEmpty_r, txDone_r, rxFull_r, idle_r, parErr_r, frmErr_r;
   logic wakeClear;

   // One wait state; ack drops the cycle after it is given
   always_ff @(posedge core_clk) begin
      if (srst) ackR <= 1'b0;
      else ackR <= access;
   end
   assign ack_o = ackR;

   // Read data captured with ack, unmapped reads return zero
   always_ff @(posedge core_clk) begin
      if (srst) dat_o <= 32'h0000_0000;
      else if (access & ~we_i) begin
         case (adr_i)
            ADR_CTRL_ONE: dat_o <= {24'h00_0000, ctrlOne_r};
            ADR_CTRL_TWO: dat_o <= {24'h00_0000, ctrlTwo_r};
            ADR_DATA: dat_o <= {23'h00_0000, rxData_r};
            ADR_STATUS: dat_o <= {24'h00_0000, txEmpty_r, txDone_r, rxFull_r, idle_r,
                                  2'b00, parErr_r, frmErr_r};
            default: dat_o <= 32'h0000_0000;
         endcase
      end
   end
   // Control register one
   always_ff @(posedge core_clk) begin
      if (srst) ctrlOne_r <= CTRL_RESET;
      else if (wrOne) ctrlOne_r <= dat_i[7:0];
   end
   // Control register two; transmitter and receiver enables frozen while the port is off
   always_ff @(posedge core_clk) begin
      if (srst) ctrlTwo_r <= CTRL_RESET;
      else begin
         if (wrTwo) begin
            ctrlTwo_r[C2_TXEIE] <= dat_i[C2_TXEIE];
            ctrlTwo_r[C2_TX_COMPLETE_IRQ_ENABLE] <= dat_i[C2_TX_COMPLETE_IRQ_ENABLE];
            ctrlTwo_r[C2_RXFIE] <= dat_i[C2_RXFIE];
            ctrlTwo_r[C2_IDLEIE] <= dat_i[C2_IDLEIE];
            ctrlTwo_r[C2_BREAK] <= dat_i[C2_BREAK];
            if (enable) begin
               ctrlTwo_r[C2_TXEN] <= dat_i[C2_TXEN];
               ctrlTwo_r[C2_RXEN] <= dat_i[C2_RXEN];
            end
         end
         // Hardware wake beats a same-cycle software write
         if (wakeClear) ctrlTwo_r[C2_STBY] <= 1'b0;
         else if (wrTwo) ctrlTwo_r[C2_STBY] <= dat_i[C2_STBY];
      end
   end

   // ****************************************
   // Transmitter
   // ****************************************
   asp_tx_type txState_r;
   logic [10:0] txShift_r;
   logic [3:0] txBits_r;
   logic [15:0] txDiv_r;
   logic preamblePend_r;
   logic txBreakSent_r;
   logic txTick;
   logic txEnable;
   logic loadFrame;

   assign txEnable = ctrlTwo_r[C2_TXEN];
   assign txTick = (txDiv_r == BIT_CYCLES - 16'h0001);
   assign loadFrame = enable & txEnable & ((txState_r == TX_IDLE) | (txTick &&
                      txBits_r == 4'h1));
   assign txBit = (txState_r == TX_SEND) ? txShift_r[0] : 1'b1;
   // Bit divider, only runs while the port is enabled
   always_ff @(posedge core_clk) begin
      if (srst || !enable || txState_r == TX_IDLE) txDiv_r <= 16'h0000;
      else if (txTick) txDiv_r <= 16'h0000;
      else txDiv_r <= txDiv_r + 16'h0001;
   end
   // Enable rising, even mid-frame, queues one idle preamble
   always_ff @(posedge core_clk) begin
      if (srst || !enable) preamblePend_r <= 1'b0;
      else if (wrTwo && dat_i[C2_TXEN] && !txEnable) preamblePend_r <= 1'b1;
      else if (loadFrame) preamblePend_r <= 1'b0;
   end
   // Frame sequencer: preamble, break, trailing one, then data
   always_ff @(posedge core_clk) begin
      if (srst || !enable) begin
         txState_r <= TX_IDLE;
         txShift_r <= 11'h7FF;
         txBits_r <= 4'h0;
         txBreakSent_r <= 1'b0;
      end else if (loadFrame) begin
         if (preamblePend_r) begin
            txState_r <= TX_SEND;
            txShift_r <= 11'h7FF;
            txBits_r <= frameLen(modeLong);
            txBreakSent_r <= 1'b0;
         end else if (ctrlTwo_r[C2_BREAK]) begin
            txState_r <= TX_SEND;
            txShift_r <= 11'h000;
            txBits_r <= frameLen(modeLong);
            txBreakSent_r <= 1'b1;
         end else if (txBreakSent_r) begin
            // A single one after the break marks a clean start bit
            txState_r <= TX_SEND;
            txShift_r <= 11'h7FF;
            txBits_r <= 4'h1;
            txBreakSent_r <= 1'b0;
         end else if (!txEmpty_r) begin
            txState_r <= TX_SEND;
            if (modeLong)
               txShift_r <= {1'b1, ctrlOne_r[C1_PAREN] ?
                  parityOf(txData_r, 1'b1, ctrlOne_r[C1_PARTY]) : txData_r[8],
                  txData_r[7:0], 1'b0};
            else
               txShift_r <= {2'b11, ctrlOne_r[C1_PAREN] ?
                  parityOf(txData_r, 1'b0, ctrlOne_r[C1_PARTY]) : txData_r[7],
                  txData_r[6:0], 1'b0};
            txBits_r <= frameLen(modeLong);
         end else begin
            txState_r <= TX_IDLE;
            txBits_r <= 4'h0;
         end
      end else if (txState_r == TX_SEND && txTick) begin
         txShift_r <= {1'b1, txShift_r[10:1]};
         txBits_r <= txBits_r - 4'h1;
         if (txBits_r == 4'h1) txState_r <= TX_IDLE;
      end
   end
   // Transmit buffer and empty flag; disabling the port sets empty
   always_ff @(posedge core_clk) begin
      if (srst) begin
         txEmpty_r <= 1'b1;
         txData_r <= 9'h000;
      end else if (!enable) txEmpty_r <= 1'b1;
      else if (loadFrame && !preamblePend_r && !ctrlTwo_r[C2_BREAK] && !txBreakSent_r
               && !txEmpty_r) txEmpty_r <= 1'b1;
      else if (wrData) begin
         txEmpty_r <= 1'b0;
         txData_r <= {sel_i[1] & dat_i[8], dat_i[7:0]};
      end
   end
   // Complete when nothing is shifting and nothing is queued
   always_ff @(posedge core_clk) begin
      if (srst) txDone_r <= 1'b1;
      else txDone_r <= !enable | (txState_r == TX_IDLE && txEmpty_r && !txBreakSent_r
                       && !preamblePend_r && !ctrlTwo_r[C2_BREAK]);
   end

   // ****************************************
   // Receiver
   // ****************************************
   asp_rx_type rxState_r;
   logic [15:0] rxDiv_r;
   logic [3:0] rxBits_r;
   logic [9:0] rxShift_r;
   logic [3:0] onesCnt_r;
   logic idleArm_r;
   logic rxTick, rxDone, idleHit, addrMark;
   logic [8:0] rxChar;
   logic rxStop, rxParBad;

   assign rxTick = (rxDiv_r == BIT_CYCLES - 16'h0001);
   assign rxDone = (rxState_r == RX_DATA) && rxTick && (rxBits_r == 4'h1);
   // Last sample is the stop bit, now entering the top of the shifter
   assign rxStop = rxLine;
   assign rxChar = modeLong ? rxShift_r[9:1] : {1'b0, rxShift_r[9:2]};
   assign addrMark = modeLong ? rxChar[8] : rxChar[7];
   assign rxParBad = ctrlOne_r[C1_PAREN] && (parityOf(rxChar, modeLong,
                     ctrlOne_r[C1_PARTY]) != (modeLong ? rxChar[8] : rxChar[7]));
   assign idleHit = (onesCnt_r == frameLen(modeLong) - 4'h1) && rxTick && rxLine
                    && rxState_r == RX_IDLE;
   // Receive bit timer, restarted by a falling edge while idle
   always_ff @(posedge core_clk) begin
      if (srst || !enable || rxTick) rxDiv_r <= 16'h0000;
      else if (rxState_r == RX_IDLE && !rxLine) rxDiv_r <= 16'h0000;
      else if (rxState_r == RX_START && rxDiv_r == HALF_BIT) rxDiv_r <= 16'h0000;
      else rxDiv_r <= rxDiv_r + 16'h0001;
   end
   // Start check at mid-bit, then one sample per bit time
   always_ff @(posedge core_clk) begin
      if (srst || !enable || !ctrlTwo_r[C2_RXEN]) begin
         rxState_r <= RX_IDLE;
         rxBits_r <= 4'h0;
         rxShift_r <= 10'h000;
      end else begin
         case (rxState_r)
            RX_IDLE: if (!rxLine) rxState_r <= RX_START;
            RX_START:
               if (rxDiv_r == HALF_BIT) begin
                  rxState_r <= rxLine ? RX_IDLE : RX_DATA;
                  rxBits_r <= frameLen(modeLong) - 4'h1;
               end
            RX_DATA:
               if (rxTick) begin
                  rxShift_r <= {rxLine, rxShift_r[9:1]};
                  rxBits_r <= rxBits_r - 4'h1;
                  if (rxBits_r == 4'h1) rxState_r <= RX_IDLE;
               end
            default: rxState_r <= RX_IDLE;
         endcase
      end
   end
   // Ones counter; idle type picks whether in-frame ones count
   always_ff @(posedge core_clk) begin
      if (srst || !enable || !ctrlTwo_r[C2_RXEN]) onesCnt_r <= 4'h0;
      else if (rxState_r == RX_START) onesCnt_r <= 4'h0;
      else if (rxState_r == RX_DATA && rxTick) begin
         if (!rxLine || ctrlOne_r[C1_IDLETY]) onesCnt_r <= 4'h0;
         else onesCnt_r <= onesCnt_r + 4'h1;
      end else if (rxState_r == RX_IDLE && rxTick && rxLine) begin
         if (idleHit) onesCnt_r <= 4'h0;
         else onesCnt_r <= onesCnt_r + 4'h1;
      end
   end
   // Wake conditions clear standby
   assign wakeClear = ctrlTwo_r[C2_STBY] & ((ctrlOne_r[C1_WAKE] & rxDone & addrMark)
                      | (~ctrlOne_r[C1_WAKE] & idleHit));

   // Receiver flags; hardware set wins over a same-cycle clearing read
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rxFull_r <= 1'b0;
         idle_r <= 1'b0;
         parErr_r <= 1'b0;
         frmErr_r <= 1'b0;
         rxData_r <= 9'h000;
         idleArm_r <= 1'b0;
      end else begin
         if (rxDone && (!ctrlTwo_r[C2_STBY] || wakeClear)) begin
            rxFull_r <= 1'b1;
            rxData_r <= rxChar;
            parErr_r <= rxParBad;
            frmErr_r <= !rxStop;
            idleArm_r <= 1'b1;
         end else if (rdData) begin
            rxFull_r <= 1'b0;
            parErr_r <= 1'b0;
            frmErr_r <= 1'b0;
         end
         // Idle wake neither flags the idle event nor disarms it
         if (idleHit && idleArm_r && !ctrlTwo_r[C2_STBY]) begin
            idle_r <= 1'b1;
            idleArm_r <= 1'b0;
         end else if (rdData) idle_r <= 1'b0;
      end
   end

   // ****************************************
   // Request outputs
   // ****************************************
   // Port off masks tx requests; standby masks rx requests
   always_ff @(posedge core_clk) begin
      if (srst) begin
         txIrq <= 1'b0;
         rxIrq <= 1'b0;
      end else begin
         txIrq <= enable & ((ctrlTwo_r[C2_TXEIE] & txEmpty_r)
                 | (ctrlTwo_r[C2_TX_COMPLETE_IRQ_ENABLE] & txDone_r));
         rxIrq <= ~ctrlTwo_r[C2_STBY] & ((ctrlTwo_r[C2_RXFIE] & rxFull_r)
                 | (ctrlTwo_r[C2_IDLEIE] & idle_r));
      end
   end
endmodule : asp_control

//--- verilog/asp_pkg.sv
// Package: register map, field positions and timing for the serial port control block
package asp_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [3:0] ADR_CTRL_ONE = 4'h0;
   localparam logic [3:0] ADR_CTRL_TWO = 4'h4;
   localparam logic [3:0] ADR_DATA = 4'h8;
   localparam logic [3:0] ADR_STATUS = 4'hC;
   // serial_control_one fields
   localparam int C1_LOOP = 7;
   localparam int C1_ENABLE = 6;
   localparam int C1_TRANSMIT_INVERT = 5;
   localparam int C1_MODE = 4;
   localparam int C1_WAKE = 3;
   localparam int C1_IDLETY = 2;
   localparam int C1_PAREN = 1;
   localparam int C1_PARTY = 0;
   // serial_control_two fields
   localparam int C2_TXEIE = 7;
   localparam int C2_TX_COMPLETE_IRQ_ENABLE = 6;
   localparam int C2_RXFIE = 5;
   localparam int C2_IDLEIE = 4;
   localparam int C2_TXEN = 3;
   localparam int C2_RXEN = 2;
   localparam int C2_STBY = 1;
   localparam int C2_BREAK = 0;
   // Status fields
   localparam int ST_TXE = 7;
   localparam int ST_TC = 6;
   localparam int ST_RXF = 5;
   localparam int ST_IDLE = 4;
   localparam int ST_PERR = 1;
   localparam int ST_FERR = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // ****************************************
   // Frame and timing
   // ****************************************
   localparam logic [3:0] FRAME_SHORT = 4'hA;
   localparam logic [3:0] FRAME_LONG = 4'hB;
   localparam int CLK_HZ = 25000000;
   localparam int BAUD_HZ = 9600;
   localparam int BIT_CYCLES_INT = CLK_HZ / BAUD_HZ;
   localparam logic [15:0] BIT_CYCLES = 16'(BIT_CYCLES_INT);
   localparam logic [15:0] HALF_BIT = 16'(BIT_CYCLES_INT / 2);
   typedef enum logic [0:0] {TX_IDLE, TX_SEND} asp_tx_type;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} asp_rx_type;
endpackage : asp_pkg
